// file: logic/mapper_pkg.sv
// What this block does
// - A page register picks which 16K flash block shows at 0x8000-0xBFFF.
// - CPU accesses inside the window use the current page to build the flash address.
// - Flash 0x4000-0x7FFF is reached directly and through the window at page 1.
// - The extended map spans 128K bytes as eight 16K pages.
// - The page register is read and written by software and by call and return.
// - Call stacks return address, pushes page, then loads new page and jumps on one edge.
// - Call takes its new page and window target from the instruction operands.
// - The call sequence cannot be interrupted and works between any two addresses.
// - Return pulls the page, then the 16-bit return address, then resumes there.
// - The return sequence cannot be interrupted and runs from any address.
// - A 17-bit linear pointer reaches every location of the extended flash map.
// - Linear data accesses advance the pointer or not, by data register used.
// - Software adds a two's-complement value to the pointer in hardware.
// - Pointer and data registers sit in direct page; word accesses reach any address.
// - After any reset the page register holds page 2.
// - Window addresses are page bits concatenated with CPU address bits 13 to 0.
// - Post-increment reads return the byte, writes store it, then the pointer increments.
// - Writing a signed byte to the adjust register adds it to the pointer.
`timescale 1ns/100ps
`default_nettype none

package mapper_pkg;

  // Address widths
  localparam int PAGE_W = 3;
  localparam int EXT_W  = 17;
  localparam int CPU_W  = 16;
  localparam int OFS_W  = 14;

  // Window decode on A15:A14
  localparam logic [1:0]        WIN_TAG     = 2'h2;
  localparam logic [PAGE_W-1:0] PAGE_RESET  = 3'h2;
  localparam logic [PAGE_W-1:0] ALIAS_PAGE  = 3'h1;

  // Register offsets in direct page
  localparam logic [7:0] OFS_PAGE  = 8'h00;
  localparam logic [7:0] OFS_PTR2  = 8'h01;
  localparam logic [7:0] OFS_PTR1  = 8'h02;
  localparam logic [7:0] OFS_PTR0  = 8'h03;
  localparam logic [7:0] OFS_LWP   = 8'h04;
  localparam logic [7:0] OFS_LBP   = 8'h05;
  localparam logic [7:0] OFS_LB    = 8'h06;
  localparam logic [7:0] OFS_ADJ   = 8'h07;

  // Pointer byte selects and reset
  localparam logic [1:0]       SEL_PTR0  = 2'h0;
  localparam logic [1:0]       SEL_PTR1  = 2'h1;
  localparam logic [1:0]       SEL_PTR2  = 2'h2;
  localparam logic [EXT_W-1:0] PTR_RESET = 17'h00000;
  localparam logic [EXT_W-1:0] PTR_STEP  = 17'h00001;

  // Stack frame of a paged call
  localparam logic [CPU_W-1:0] SP_ONE   = 16'h0001;
  localparam logic [CPU_W-1:0] SP_TWO   = 16'h0002;
  localparam logic [CPU_W-1:0] SP_FRAME = 16'h0003;

  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_C_HI  = 7'h02,
    S_C_PG  = 7'h04,
    S_C_LD  = 7'h08,
    S_R_PCH = 7'h10,
    S_R_PCL = 7'h20,
    S_R_END = 7'h40
  } seq_state_e;

  // CPU address inside the paging window
  function automatic logic in_window(input logic [CPU_W-1:0] a);
    return a[15:14] == WIN_TAG;
  endfunction : in_window

  // Linear data registers reach flash through the pointer
  function automatic logic is_data_reg(input logic [7:0] a);
    return (a == OFS_LWP) || (a == OFS_LBP) || (a == OFS_LB);
  endfunction : is_data_reg

  // Data registers that step the pointer after the access
  function automatic logic is_postinc(input logic [7:0] a);
    return (a == OFS_LWP) || (a == OFS_LBP);
  endfunction : is_postinc

  // Window gets page:A13:A0, everything else zero-extended
  function automatic logic [EXT_W-1:0] map_addr(input logic [PAGE_W-1:0] pg,
                                                input logic [CPU_W-1:0]  a);
    if (in_window(a))
      return {pg, a[OFS_W-1:0]};
    return {1'b0, a};
  endfunction : map_addr

endpackage : mapper_pkg

////////////////////////////////////////////////////////////////////////////////

module linear_pointer_unit
  import mapper_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       ce,
  input  wire logic                       byte_wr,
  input  wire logic [1:0]                 byte_sel,
  input  wire logic [7:0]                 wr_data,
  input  wire logic                       step,
  input  wire logic                       adj_wr,
  output logic      [mapper_pkg::EXT_W-1:0] pointer
);

  logic [EXT_W-1:0] adj_ext;

  // Sign-extend the adjust byte to pointer width
  assign adj_ext = {{(EXT_W-8){wr_data[7]}}, wr_data};

  // Sums stay 17 bits so the pointer wraps by itself
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      pointer <= PTR_RESET;
    else if (ce)
    begin
      if (adj_wr)
        pointer <= pointer + adj_ext;
      else if (step)
        pointer <= pointer + PTR_STEP;
      else if (byte_wr)
      begin
        case (byte_sel)
          SEL_PTR2: pointer[16] <= wr_data[0];
          SEL_PTR1: pointer[15:8] <= wr_data;
          SEL_PTR0: pointer[7:0] <= wr_data;
          default:  pointer <= pointer;
        endcase
      end
    end
  end

endmodule : linear_pointer_unit

`default_nettype wire

// file: logic/paged_memory_window_mapper.sv
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module paged_memory_window_mapper
  import mapper_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic                          ce,
  // Register port, direct page
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [7:0]                    reg_rdata,
  // CPU memory access
  input  wire logic [mapper_pkg::CPU_W-1:0]  cpu_addr,
  input  wire logic                          cpu_rd,
  input  wire logic                          cpu_wr,
  input  wire logic [7:0]                    cpu_wdata,
  // Flash decode side
  output logic      [mapper_pkg::EXT_W-1:0]  ext_addr,
  output logic                               mem_rd,
  output logic                               mem_wr,
  output logic      [7:0]                    mem_wdata,
  input  wire logic [7:0]                    mem_rdata,
  // Paged call and return from the core
  input  wire logic                          call_req,
  input  wire logic [7:0]                    call_page,
  input  wire logic [mapper_pkg::CPU_W-1:0]  call_target,
  input  wire logic [mapper_pkg::CPU_W-1:0]  ret_addr,
  input  wire logic                          ret_req,
  input  wire logic [mapper_pkg::CPU_W-1:0]  sp,
  // Stack memory
  output logic                               stk_wr,
  output logic                               stk_rd,
  output logic      [mapper_pkg::CPU_W-1:0]  stk_addr,
  output logic      [7:0]                    stk_wdata,
  input  wire logic [7:0]                    stk_rdata,
  // Results to the core
  output logic                               pc_load,
  output logic      [mapper_pkg::CPU_W-1:0]  pc_value,
  output logic                               sp_load,
  output logic      [mapper_pkg::CPU_W-1:0]  sp_value,
  output logic                               irq_block,
  output logic      [mapper_pkg::PAGE_W-1:0] program_page_select,
  output logic      [mapper_pkg::EXT_W-1:0]  linear_pointer
);

  import mapper_pkg::*;

  seq_state_e        state;
  logic [CPU_W-1:0]  sp_q;
  logic [CPU_W-1:0]  target_q;
  logic [CPU_W-1:0]  ret_q;
  logic [PAGE_W-1:0] new_page_q;
  logic [7:0]        pch_q;
  logic              data_acc;
  logic              ptr_byte_wr;
  logic [1:0]        ptr_sel;
  logic              ptr_step;
  logic              ptr_adj;
  logic              sel_mem_q;
  logic [7:0]        rdata_q;
  logic [7:0]        next_rdata;

  //////////////////////////////////////////////////////////////////////////////
  // Linear pointer decode

  // A data register hit takes the flash port this cycle
  assign data_acc    = (reg_rd || reg_wr) && is_data_reg(reg_addr);
  assign ptr_step    = (reg_rd || reg_wr) && is_postinc(reg_addr);
  assign ptr_adj     = reg_wr && (reg_addr == OFS_ADJ);
  assign ptr_byte_wr = reg_wr && (reg_addr == OFS_PTR2 || reg_addr == OFS_PTR1 ||
                                  reg_addr == OFS_PTR0);
  assign ptr_sel     = (reg_addr == OFS_PTR2) ? SEL_PTR2 :
                       (reg_addr == OFS_PTR1) ? SEL_PTR1 : SEL_PTR0;

  linear_pointer_unit u_ptr
  (
    .clk      (clk),
    .rst_b    (rst_b),
    .ce       (ce),
    .byte_wr  (ptr_byte_wr),
    .byte_sel (ptr_sel),
    .wr_data  (reg_wdata),
    .step     (ptr_step),
    .adj_wr   (ptr_adj),
    .pointer  (linear_pointer)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Page register

  // Sequencer loads beat software writes; only one happens per instruction
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      program_page_select <= PAGE_RESET;
    else if (ce)
    begin
      if (state == S_C_LD)
        program_page_select <= new_page_q;
      else if (state == S_R_PCH)
        program_page_select <= stk_rdata[PAGE_W-1:0];
      else if (reg_wr && reg_addr == OFS_PAGE)
        program_page_select <= reg_wdata[PAGE_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Flash port

  // Registered so decode sees a clean address; pointer is sampled before its step
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ext_addr  <= PTR_RESET;
      mem_rd    <= 1'b0;
      mem_wr    <= 1'b0;
      mem_wdata <= 8'h00;
    end
    else if (ce)
    begin
      if (data_acc)
      begin
        ext_addr  <= linear_pointer;
        mem_rd    <= reg_rd;
        mem_wr    <= reg_wr;
        mem_wdata <= reg_wdata;
      end
      else
      begin
        ext_addr  <= map_addr(program_page_select, cpu_addr);
        mem_rd    <= cpu_rd;
        mem_wr    <= cpu_wr;
        mem_wdata <= cpu_wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register read data

  // Narrow registers read zero above their width
  always_comb
  begin
    next_rdata = 8'h00;
    case (reg_addr)
      OFS_PAGE: next_rdata = {5'h00, program_page_select};
      OFS_PTR2: next_rdata = {7'h00, linear_pointer[16]};
      OFS_PTR1: next_rdata = linear_pointer[15:8];
      OFS_PTR0: next_rdata = linear_pointer[7:0];
      default:  next_rdata = 8'h00;
    endcase
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rdata_q   <= 8'h00;
      sel_mem_q <= 1'b0;
    end
    else if (ce)
    begin
      rdata_q   <= reg_rd ? next_rdata : 8'h00;
      sel_mem_q <= reg_rd && is_data_reg(reg_addr);
    end
  end

  // Flash byte passes straight through so the port never waits
  assign reg_rdata = sel_mem_q ? mem_rdata : rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Call and return sequencer

  // Interrupts held off for the whole frame
  assign irq_block = (state != S_IDLE);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state      <= S_IDLE;
      sp_q       <= 16'h0000;
      target_q   <= 16'h0000;
      ret_q      <= 16'h0000;
      new_page_q <= 3'h0;
      pch_q      <= 8'h00;
      stk_wr     <= 1'b0;
      stk_rd     <= 1'b0;
      stk_addr   <= 16'h0000;
      stk_wdata  <= 8'h00;
      pc_load    <= 1'b0;
      pc_value   <= 16'h0000;
      sp_load    <= 1'b0;
      sp_value   <= 16'h0000;
    end
    else if (ce)
    begin
      stk_wr  <= 1'b0;
      stk_rd  <= 1'b0;
      pc_load <= 1'b0;
      sp_load <= 1'b0;
      case (state)
        S_IDLE:
        begin
          // Call wins if both arrive; requests while busy are not seen
          if (call_req)
          begin
            sp_q       <= sp;
            target_q   <= call_target;
            ret_q      <= ret_addr;
            new_page_q <= call_page[PAGE_W-1:0];
            stk_wr     <= 1'b1;
            stk_addr   <= sp;
            stk_wdata  <= ret_addr[7:0];
            state      <= S_C_HI;
          end
          else if (ret_req)
          begin
            sp_q     <= sp;
            stk_rd   <= 1'b1;
            stk_addr <= sp + SP_ONE;
            state    <= S_R_PCH;
          end
        end
        S_C_HI:
        begin
          stk_wr    <= 1'b1;
          stk_addr  <= sp_q - SP_ONE;
          stk_wdata <= ret_q[15:8];
          state     <= S_C_PG;
        end
        S_C_PG:
        begin
          stk_wr    <= 1'b1;
          stk_addr  <= sp_q - SP_TWO;
          stk_wdata <= {5'h00, program_page_select};
          state     <= S_C_LD;
        end
        S_C_LD:
        begin
          // New page and jump show together next cycle; both are loaded on the same edge
          pc_load  <= 1'b1;
          pc_value <= target_q;
          sp_load  <= 1'b1;
          sp_value <= sp_q - SP_FRAME;
          state    <= S_IDLE;
        end
        S_R_PCH:
        begin
          stk_rd   <= 1'b1;
          stk_addr <= sp_q + SP_TWO;
          state    <= S_R_PCL;
        end
        S_R_PCL:
        begin
          pch_q    <= stk_rdata;
          stk_rd   <= 1'b1;
          stk_addr <= sp_q + SP_FRAME;
          state    <= S_R_END;
        end
        S_R_END:
        begin
          pc_load  <= 1'b1;
          pc_value <= {pch_q, stk_rdata};
          sp_load  <= 1'b1;
          sp_value <= sp_q + SP_FRAME;
          state    <= S_IDLE;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_page_reset: assert property (
    @(posedge clk) !rst_b |=> program_page_select == PAGE_RESET)
    else $error("page not reset to 2");

  chk_window_map: assert property (
    @(posedge clk) disable iff (!rst_b || !ce)
    (!data_acc && in_window(cpu_addr)) |=>
      ext_addr == {$past(program_page_select), $past(cpu_addr[13:0])})
    else $error("window address not paged");

  chk_outside_pass: assert property (
    @(posedge clk) disable iff (!rst_b || !ce)
    (!data_acc && !in_window(cpu_addr)) |=> ext_addr == {1'b0, $past(cpu_addr)})
    else $error("outside address altered");

  chk_alias_page: assert property (
    @(posedge clk) disable iff (!rst_b || !ce)
    (!data_acc && program_page_select == ALIAS_PAGE && in_window(cpu_addr)) |=>
      ext_addr == {1'b0, 2'h1, $past(cpu_addr[13:0])})
    else $error("page 1 does not alias direct flash");

  chk_ptr_step: assert property (
    @(posedge clk) disable iff (!rst_b || !ce)
    ptr_step |=> (linear_pointer == $past(linear_pointer) + PTR_STEP) &&
                 (ext_addr == $past(linear_pointer)))
    else $error("post-increment access wrong");

  chk_ptr_adjust: assert property (
    @(posedge clk) disable iff (!rst_b || !ce)
    ptr_adj |=> linear_pointer ==
      $past(linear_pointer) + {{9{$past(reg_wdata[7])}}, $past(reg_wdata)})
    else $error("pointer adjust wrong");

  chk_plain_byte: assert property (
    @(posedge clk) disable iff (!rst_b || !ce)
    (reg_rd && reg_addr == OFS_LB) |=> linear_pointer == $past(linear_pointer))
    else $error("plain byte access moved pointer");

  chk_call_order: assert property (
    @(posedge clk) disable iff (!rst_b || !ce)
    (state == S_IDLE && call_req) |=>
      (stk_wr && stk_wdata == $past(ret_addr[7:0])) ##1
      (stk_wr && stk_addr == sp_q - SP_ONE) ##1
      (stk_wr && stk_wdata == {5'h00, program_page_select} && !pc_load) ##1
      (program_page_select == new_page_q && pc_load &&
       pc_value == target_q))
    else $error("call sequence out of order");

  chk_ret_pulls: assert property (
    @(posedge clk) disable iff (!rst_b || !ce)
    (state == S_R_PCH) |=> (program_page_select == $past(stk_rdata[2:0])) ##2
      (pc_load && sp_value == sp_q + SP_FRAME))
    else $error("return sequence wrong");

  chk_irq_block: assert property (
    @(posedge clk) disable iff (!rst_b || !ce)
    (state == S_IDLE && (call_req || ret_req)) |=> irq_block [*3] ##1 !irq_block)
    else $error("sequence not shielded from interrupts");

endmodule : paged_memory_window_mapper

`default_nettype wire

// file: tb/far_side_model.sv
`timescale 1ns/100ps
`default_nettype none

module far_side_model (
  input  wire logic        clk,
  input  wire logic [16:0] ext_addr,
  input  wire logic        mem_rd,
  output logic      [7:0]  mem_rdata,
  input  wire logic        stk_wr,
  input  wire logic        stk_rd,
  input  wire logic [15:0] stk_addr,
  input  wire logic [7:0]  stk_wdata,
  output logic      [7:0]  stk_rdata
);
  logic [7:0] stk [256];
  logic [7:0] last_m = 8'h00;
  logic [7:0] last_s = 8'h00;

  // Answers only in the strobe cycle; a released bus shows junk, not stale data
  assign mem_rdata = mem_rd ? (ext_addr[7:0] ^ {5'h00, ext_addr[16:14]}) : ~last_m;
  assign stk_rdata = stk_rd ? stk[stk_addr[7:0]] : ~last_s;

  // Stack RAM and last driven bytes
  always @(posedge clk)
  begin
    if (stk_wr)
      stk[stk_addr[7:0]] <= stk_wdata;
    if (mem_rd)
      last_m <= mem_rdata;
    if (stk_rd)
      last_s <= stk_rdata;
  end
endmodule : far_side_model

`default_nettype wire

// file: tb/test_paged_memory_window_mapper.sv
`timescale 1ns/100ps
`default_nettype none

module test_paged_memory_window_mapper;
  import mapper_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, cpu_wdata, mem_wdata, mem_rdata;
  logic [7:0]  call_page, stk_wdata, stk_rdata, d;
  logic        reg_wr, reg_rd, cpu_rd, cpu_wr, mem_rd, mem_wr, call_req, ret_req;
  logic        stk_wr, stk_rd, pc_load, sp_load, irq_block;
  logic        ce = 1'b1;
  logic [15:0] cpu_addr, call_target, ret_addr, sp, stk_addr, pc_value, sp_value;
  logic [16:0] ext_addr, linear_pointer;
  logic [2:0]  program_page_select;
  int          err_count = 0;
  int          n_compared = 0;
  int          cycles = 0;

  paged_memory_window_mapper DUT (.clk(clk), .rst_b(rst_b), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
    .cpu_wdata(cpu_wdata), .ext_addr(ext_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .call_req(call_req),
    .call_page(call_page), .call_target(call_target), .ret_addr(ret_addr),
    .ret_req(ret_req), .sp(sp), .stk_wr(stk_wr), .stk_rd(stk_rd), .stk_addr(stk_addr),
    .stk_wdata(stk_wdata), .stk_rdata(stk_rdata), .pc_load(pc_load),
    .pc_value(pc_value), .sp_load(sp_load), .sp_value(sp_value), .irq_block(irq_block),
    .program_page_select(program_page_select), .linear_pointer(linear_pointer));

  far_side_model u_far (.clk(clk), .ext_addr(ext_addr), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata), .stk_wr(stk_wr), .stk_rd(stk_rd), .stk_addr(stk_addr),
    .stk_wdata(stk_wdata), .stk_rdata(stk_rdata));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; run needs well under a thousand cycles
  initial
  begin
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared bus and compare tasks
  function automatic logic [7:0] fdat(input logic [16:0] a);
    return a[7:0] ^ {5'h00, a[16:14]};
  endfunction : fdat

  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic cpu(input logic [15:0] a, input logic [16:0] exp, input logic w = 1'b0);
    @(posedge clk);
    cpu_addr <= a;
    cpu_rd <= !w;
    cpu_wr <= w;
    cpu_wdata <= 8'h3c;
    @(posedge clk);
    cpu_rd <= 1'b0;
    cpu_wr <= 1'b0;
    #1 chk("ext_addr", exp, ext_addr);
    chk("mem_rd", {16'h0000, !w}, {16'h0000, mem_rd});
    chk("mem_wr", {16'h0000, w}, {16'h0000, mem_wr});
    chk("mem_wdata", 17'h3c, mem_wdata);
  endtask : cpu

  // Polls past the request edge; a late or early jump shows as a count mismatch
  task automatic wait_pc(input logic [16:0] n);
    int k;
    k = 0;
    while (pc_load !== 1'b1 && k < 10)
    begin
      @(posedge clk);
      #1 k++;
    end
    chk("pc_load delay", n, 17'(k));
    chk("sp_load", 17'h1, {16'h0000, sp_load});
  endtask : wait_pc

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk("page", 17'h2, program_page_select);
    rd(OFS_PAGE);
    chk("page read", 17'h2, d);
    chk("pointer", 17'h0, linear_pointer);
    rd(8'h20);
    chk("unmapped read", 17'h0, d);
  endtask : t_reset

  // Mid-run reset; address parked at zero so the flash port reset value matches
  task automatic t_reset2();
    @(posedge clk);
    cpu_addr <= 16'h0000;
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    #1 chk("page", 17'h2, program_page_select);
    chk("pointer", 17'h0, linear_pointer);
  endtask : t_reset2

  // Enable low freezes state; strobes in that time are lost
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    wr(OFS_PAGE, 8'h06);
    wr(OFS_ADJ, 8'h10);
    chk("frozen page", 17'h2, program_page_select);
    chk("frozen pointer", 17'h0, linear_pointer);
    @(posedge clk);
    ce <= 1'b1;
  endtask : t_freeze

  task automatic t_window();
    cpu(16'h8123, 17'h08123);
    cpu(16'h9abc, 17'h09abc, 1'b1);
    cpu(16'h4123, 17'h04123);
    cpu(16'hc000, 17'h0c000);
    // Page writes come from unpaged code only
    for (int p = 0; p < 8; p++)
    begin
      wr(OFS_PAGE, 8'(p));
      rd(OFS_PAGE);
      chk("page read", 17'(p), d);
      cpu(16'hbfff, {p[2:0], 14'h3fff});
    end
    wr(OFS_PAGE, 8'h01);
    cpu(16'h8123, 17'h04123);
  endtask : t_window

  task automatic t_pointer();
    wr(OFS_PTR2, 8'h01);
    wr(OFS_PTR1, 8'hff);
    wr(OFS_PTR0, 8'hff);
    chk("pointer", 17'h1ffff, linear_pointer);
    rd(OFS_LB);
    chk("ext_addr", 17'h1ffff, ext_addr);
    chk("lb data", 17'(fdat(17'h1ffff)), d);
    chk("pointer", 17'h1ffff, linear_pointer);
    rd(OFS_LBP);
    chk("lbp data", 17'(fdat(17'h1ffff)), d);
    chk("pointer", 17'h00000, linear_pointer);
    wr(OFS_ADJ, 8'hff);
    chk("pointer", 17'h1ffff, linear_pointer);
    wr(OFS_ADJ, 8'h02);
    chk("pointer", 17'h00001, linear_pointer);
    wr(OFS_ADJ, 8'h80);
    chk("pointer", 17'h1ff81, linear_pointer);
    wr(OFS_LWP, 8'ha5);
    chk("mem_wr", 17'h1, {16'h0000, mem_wr});
    chk("ext_addr", 17'h1ff81, ext_addr);
    chk("mem_wdata", 17'ha5, mem_wdata);
    wr(OFS_LBP, 8'h5a);
    chk("ext_addr", 17'h1ff82, ext_addr);
    chk("mem_wdata", 17'h5a, mem_wdata);
    chk("pointer", 17'h1ff83, linear_pointer);
  endtask : t_pointer

  task automatic t_call_return();
    wr(OFS_PAGE, 8'h03);
    @(posedge clk);
    call_req <= 1'b1;
    call_page <= 8'h05;
    call_target <= 16'h8400;
    ret_addr <= 16'h1234;
    sp <= 16'h0080;
    @(posedge clk);
    call_req <= 1'b0;
    #1 chk("irq_block", 17'h1, {16'h0000, irq_block});
    wait_pc(17'h3);
    chk("pc", 17'h08400, pc_value);
    chk("sp", 17'h0007d, sp_value);
    chk("page", 17'h5, program_page_select);
    chk("stack pcl", 17'h34, u_far.stk[8'h80]);
    chk("stack pch", 17'h12, u_far.stk[8'h7f]);
    chk("stack page", 17'h03, u_far.stk[8'h7e]);
    @(posedge clk);
    ret_req <= 1'b1;
    sp <= 16'h007d;
    @(posedge clk);
    ret_req <= 1'b0;
    #1 chk("irq_block", 17'h1, {16'h0000, irq_block});
    wait_pc(17'h3);
    chk("pc", 17'h01234, pc_value);
    chk("sp", 17'h00080, sp_value);
    chk("page", 17'h3, program_page_select);
  endtask : t_call_return

  ////////////////////////////////////////////////////////////////////////////////
  // Closing report, reached from the main sequence or the hang guard
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  // Main sequence
  initial
  begin
    {reg_addr, reg_wdata, cpu_wdata, call_page} = '0;
    {reg_wr, reg_rd, cpu_rd, cpu_wr, call_req, ret_req} = '0;
    {cpu_addr, call_target, ret_addr, sp} = '0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    #1 t_reset();
    t_window();
    t_pointer();
    t_call_return();
    t_reset2();
    t_freeze();
    conclude();
  end
endmodule : test_paged_memory_window_mapper

`default_nettype wire
